// [hdl/cfdw_pkg.sv]
package cfdw_pkg;
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_HWIN = 8'h10;
  localparam logic [7:0] OFS_VWIN = 8'h14;
  localparam logic [7:0] OFS_BASE0 = 8'h20;
  localparam logic [7:0] OFS_BASE1 = 8'h28;
  localparam logic [7:0] OFS_BASE2 = 8'h30;
  localparam logic [7:0] OFS_STRIDE = 8'h38;
  localparam logic [7:0] OFS_MIRROR = 8'h3c;
  localparam logic [7:0] OFS_CAPCTL = 8'h48;
  localparam logic [7:0] OFS_CAPSTA = 8'h4c;
  localparam logic [7:0] OFS_MASK = 8'h50;
  localparam logic [7:0] OFS_STATUS = 8'h54;
  localparam logic [7:0] OFS_FTIMER = 8'h60;
  localparam logic [31:0] RST_HWIN = 32'h0500_0000;
  localparam logic [31:0] RST_VWIN = 32'h02d0_0000;
  localparam logic [31:0] RST_STRIDE = 32'h0280_0500;
  localparam logic [31:0] RST_MIRROR = 32'h02d0_0500;
  // status bit positions
  localparam int ST_CAPDONE = 0;
  localparam int ST_FRMDONE = 1;
  localparam int ST_Q0OVF = 2;
  localparam int ST_HBOVF = 6;
  localparam int ST_VSYNC = 7;
  // frame timer tick divider, 12.5 MHz from 125 MHz
  localparam int FT_TICK_DIV = 10;
  typedef enum logic [1:0] {
    CFDW_IN_RAW = 2'b00,
    CFDW_IN_YUV422 = 2'b01,
    CFDW_IN_YUV420 = 2'b10
  } cfdw_infmt_t;
  typedef enum logic [1:0] {
    CFDW_IDLE = 2'b00,
    CFDW_VIDEO = 2'b01,
    CFDW_STILL = 2'b10,
    CFDW_DRAIN = 2'b11
  } cfdw_state_t;
endpackage

// [hdl/cfdw_frame_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module cfdw_frame_timer
  import cfdw_pkg::*;
#(
  parameter int DIV = FT_TICK_DIV
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sample,
  output logic [23:0] count_sampled
);
  initial if (DIV < 1 || DIV > 256) $error("divider must be 1 to 256");
  logic [7:0] div_cnt;
  logic tick;
  logic [23:0] running;
  // slow tick enable; the timer keeps one clock domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) div_cnt <= 8'h00;
    else if (!enable || div_cnt == 8'(DIV - 1)) div_cnt <= 8'h00;
    else div_cnt <= div_cnt + 8'h01;
  end
  assign tick = enable && div_cnt == 8'(DIV - 1);
  // counter sampled then cleared at the chosen frame event
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      running <= 24'h00_0000;
      count_sampled <= 24'h00_0000;
    end
    else if (!enable) running <= 24'h00_0000;
    else if (sample)
    begin
      count_sampled <= running;
      running <= 24'h00_0000;
    end
    else if (tick) running <= running + 24'h00_0001;
  end
endmodule
`default_nettype wire

// [hdl/cfdw_addr_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module cfdw_addr_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [31:0] base,
  input wire logic [13:0] stride,
  input wire logic [12:0] line_idx,
  input wire logic [12:0] pix_idx,
  input wire logic [2:0] bytes_pp,
  output logic [31:0] addr
);
  logic [26:0] line_ofs;
  logic [15:0] pix_ofs;
  assign line_ofs = 27'(line_idx * stride);
  assign pix_ofs = 16'(pix_idx * bytes_pp);
  // registered so the write port sees a flop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) addr <= 32'h0000_0000;
    else if (load) addr <= base + 32'(line_ofs) + 32'(pix_ofs);
  end
endmodule
`default_nettype wire

// [hdl/cfdw_top.sv]
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module cfdw_top
  import cfdw_pkg::*;
#(
  parameter int TIMER_DIV = FT_TICK_DIV
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] input_format,
  input wire logic bt656_mode,
  input wire logic pix_vsync,
  input wire logic pix_valid,
  input wire logic pix_sol,
  input wire logic [1:0] pix_plane,
  input wire logic [31:0] pix_data,
  input wire logic pix_field,
  input wire logic field_end,
  input wire logic hblank_done,
  input wire logic [2:0] queue_overflow,
  output logic mem_wr_valid,
  output logic [1:0] mem_wr_plane,
  output logic [31:0] mem_wr_addr,
  output logic [31:0] mem_wr_data,
  output logic [11:0] min_burst_bytes,
  output logic irq
);
  logic rst_meta, rst_n;
  // release the async reset through two flops
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software visible state
  logic [2:0] transfer_enable;
  logic [31:0] transfer_config, horizontal_window, vertical_window;
  logic [31:0] plane0_base_addr, plane1_base_addr, plane2_base_addr;
  logic [31:0] line_stride, mirror_size;
  logic [7:0] irq_mask, irq_status, next_status;
  logic video_on, still_req;
  logic [23:0] frame_clocks;

  wire dma_on = transfer_enable[0];
  wire frame_timer_on = transfer_enable[1];
  wire frame_timer_sample_sel = transfer_enable[2];
  wire [7:0] alpha_fill_byte = transfer_config[31:24];
  wire [3:0] memory_layout_code = transfer_config[19:16];
  wire vertical_mirror_on = transfer_config[13];
  wire horizontal_mirror_on = transfer_config[12];
  wire [1:0] field_choice = transfer_config[11:10];
  wire [1:0] frame_skip_ratio = transfer_config[7:6];
  wire [1:0] burst_code = transfer_config[1:0];
  wire [12:0] line_pixel_count = horizontal_window[28:16];
  wire [12:0] line_first_pixel = horizontal_window[12:0];
  wire [12:0] frame_line_count = vertical_window[28:16];
  wire [12:0] frame_first_line = vertical_window[12:0];
  wire [13:0] luma_line_stride = line_stride[13:0];
  wire [13:0] chroma_line_stride = line_stride[29:16];
  wire [12:0] mirror_line_count = mirror_size[28:16];
  wire [12:0] mirror_line_width = mirror_size[12:0];

  // layout legality per input format
  function automatic logic layout_ok(input logic [1:0] fmt, input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (fmt)
      CFDW_IN_RAW: ok = code[1:0] != 2'b11 && !(code[2] && code[1:0] == 2'b00 && 1'b0);
      CFDW_IN_YUV422: ok = 1'b1;
      CFDW_IN_YUV420: ok = code[1:0] == 2'b01 || code == 4'b1111
        || (code[1:0] == 2'b10 && code != 4'b1110);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // bytes stored per pixel for the chosen layout
  function automatic logic [2:0] pixel_bytes(input logic [1:0] fmt, input logic [3:0] code);
    logic [2:0] b;
    b = 3'd1;
    if (fmt == CFDW_IN_RAW)
    begin
      case (code[2:0])
        3'b000: b = 3'd1;
        3'b101: b = 3'd3;
        3'b110: b = 3'd4;
        default: b = 3'd2;
      endcase
    end
    else if (code[3:2] == 2'b11) b = 3'd2; // ten bit samples
    return b;
  endfunction

  // frame planar 420 under either yuv input
  wire frame_planar_420 = input_format != CFDW_IN_RAW && memory_layout_code == 4'b0010;
  // bt656 ends that layout on field 2
  wire frame_end = field_end && (!bt656_mode || !frame_planar_420 || pix_field);

  // register writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transfer_enable <= 3'b000;
      transfer_config <= 32'h0000_0000;
      horizontal_window <= RST_HWIN;
      vertical_window <= RST_VWIN;
      plane0_base_addr <= 32'h0000_0000;
      plane1_base_addr <= 32'h0000_0000;
      plane2_base_addr <= 32'h0000_0000;
      line_stride <= RST_STRIDE;
      mirror_size <= RST_MIRROR;
      irq_mask <= 8'h00;
      video_on <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_ENABLE: transfer_enable <= reg_wdata[2:0];
        OFS_CONFIG: transfer_config <= reg_wdata & 32'hff0f_3cc3;
        OFS_HWIN: horizontal_window <= reg_wdata & 32'h1fff_1fff;
        OFS_VWIN: vertical_window <= reg_wdata & 32'h1fff_1fff;
        OFS_BASE0: plane0_base_addr <= reg_wdata;
        OFS_BASE1: plane1_base_addr <= reg_wdata;
        OFS_BASE2: plane2_base_addr <= reg_wdata;
        OFS_STRIDE: line_stride <= reg_wdata & 32'h3fff_3fff;
        OFS_MIRROR: mirror_size <= reg_wdata & 32'h1fff_1fff;
        OFS_MASK: irq_mask <= reg_wdata[7:0];
        OFS_CAPCTL: video_on <= reg_wdata[1];
        default: ;
      endcase
    end
  end

  // still request self-clears at next vsync
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) still_req <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CAPCTL && reg_wdata[0]) still_req <= 1'b1;
    else if (pix_vsync) still_req <= 1'b0;
  end

  // frame skip decided at each vsync, field gating from the live pix_field
  logic [1:0] skip_cnt;
  logic keep_frame;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      skip_cnt <= 2'b00;
      keep_frame <= 1'b0;
    end
    else if (pix_vsync)
    begin
      keep_frame <= skip_cnt == 2'b00;
      skip_cnt <= (skip_cnt >= frame_skip_ratio) ? 2'b00 : skip_cnt + 2'b01;
    end
  end
  wire field_ok = field_choice == 2'b10 || (field_choice == 2'b00 && !pix_field)
    || (field_choice == 2'b01 && pix_field);

  // capture sequencing
  cfdw_state_t state, next_state;
  logic cap_done_ev, frm_done_ev;
  always_comb
  begin
    next_state = state;
    cap_done_ev = 1'b0;
    frm_done_ev = 1'b0;
    case (state)
      CFDW_IDLE:
        if (pix_vsync && still_req) next_state = CFDW_STILL;
        else if (pix_vsync && video_on) next_state = CFDW_VIDEO;
      CFDW_VIDEO:
        if (frame_end)
        begin
          frm_done_ev = 1'b1;
          if (!video_on)
          begin
            cap_done_ev = 1'b1;
            next_state = CFDW_IDLE;
          end
        end
        else if (!video_on) next_state = CFDW_DRAIN;
      CFDW_DRAIN:
        if (frame_end)
        begin
          cap_done_ev = 1'b1;
          next_state = CFDW_IDLE;
        end
      CFDW_STILL:
        if (frame_end)
        begin
          cap_done_ev = 1'b1;
          next_state = CFDW_IDLE;
        end
      default: next_state = CFDW_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) state <= CFDW_IDLE;
    else state <= next_state;
  end
  wire capturing = state != CFDW_IDLE;

  // bases latched at vsync so late writes hit the next frame
  logic [31:0] live_base0, live_base1, live_base2;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      live_base0 <= 32'h0000_0000;
      live_base1 <= 32'h0000_0000;
      live_base2 <= 32'h0000_0000;
    end
    else if (pix_vsync)
    begin
      live_base0 <= plane0_base_addr;
      live_base1 <= plane1_base_addr;
      live_base2 <= plane2_base_addr;
    end
  end

  // pixel and line position within the frame
  logic [12:0] hcount, vcount;
  logic line_seen;
  wire [12:0] cur_pix = pix_sol ? 13'h0000 : hcount;
  wire [12:0] cur_line = pix_sol ? (line_seen ? vcount + 13'h0001 : 13'h0000) : vcount;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hcount <= 13'h0000;
      vcount <= 13'h0000;
      line_seen <= 1'b0;
    end
    else if (pix_vsync)
    begin
      vcount <= 13'h0000;
      line_seen <= 1'b0;
    end
    else if (pix_valid)
    begin
      hcount <= cur_pix + 13'h0001;
      vcount <= cur_line;
      line_seen <= 1'b1;
    end
  end

  // crop window, wide compare avoids wrap
  wire [13:0] h_end = {1'b0, line_first_pixel} + {1'b0, line_pixel_count};
  wire [13:0] v_end = {1'b0, frame_first_line} + {1'b0, frame_line_count};
  wire in_h = cur_pix >= line_first_pixel && {1'b0, cur_pix} < h_end;
  wire in_v = cur_line >= frame_first_line && {1'b0, cur_line} < v_end;
  wire [12:0] x_rel = cur_pix - line_first_pixel;
  wire [12:0] y_rel = cur_line - frame_first_line;
  // mirror counts from flip sizes
  wire [12:0] x_pos = horizontal_mirror_on ? mirror_line_width - 13'h0001 - x_rel : x_rel;
  wire [12:0] y_pos = vertical_mirror_on ? mirror_line_count - 13'h0001 - y_rel : y_rel;
  wire layout_good = layout_ok(input_format, memory_layout_code);
  wire take = pix_valid && dma_on && capturing && keep_frame && field_ok
    && layout_good && in_h && in_v;

  // plane base and stride for the address unit
  logic [31:0] sel_base;
  logic [13:0] sel_stride;
  always_comb
  begin
    case (pix_plane)
      2'b01: sel_base = live_base1;
      2'b10: sel_base = live_base2;
      default: sel_base = live_base0;
    endcase
    sel_stride = (pix_plane == 2'b00) ? luma_line_stride : chroma_line_stride;
  end

  cfdw_addr_gen u_addr (
    .clk(sys_clk),
    .rst_n(rst_n),
    .load(take),
    .base(sel_base),
    .stride(sel_stride),
    .line_idx(y_pos),
    .pix_idx(x_pos),
    .bytes_pp(pixel_bytes(input_format, memory_layout_code)),
    .addr(mem_wr_addr)
  );

  // strobe and data align with address
  wire padded = input_format == CFDW_IN_RAW && memory_layout_code[2:0] == 3'b110;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_valid <= 1'b0;
      mem_wr_plane <= 2'b00;
      mem_wr_data <= 32'h0000_0000;
    end
    else
    begin
      mem_wr_valid <= take;
      if (take)
      begin
        mem_wr_plane <= pix_plane;
        mem_wr_data <= padded ? {alpha_fill_byte, pix_data[23:0]} : pix_data;
      end
    end
  end

  // horizontal mirroring forces smallest bursts
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) min_burst_bytes <= 12'h100;
    else if (horizontal_mirror_on) min_burst_bytes <= 12'h100;
    else min_burst_bytes <= 12'(12'h100 << burst_code);
  end

  // frame statistics timer
  cfdw_frame_timer #(
    .DIV(TIMER_DIV)
  ) u_timer (
    .clk(sys_clk),
    .rst_n(rst_n),
    .enable(frame_timer_on),
    .sample(frame_timer_sample_sel ? pix_vsync : frm_done_ev || cap_done_ev),
    .count_sampled(frame_clocks)
  );

  // field parity follows the incoming stream
  logic current_field_flag;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) current_field_flag <= 1'b0;
    else if (pix_valid || field_end) current_field_flag <= pix_field;
  end
  wire video_grab_active = state == CFDW_VIDEO || state == CFDW_DRAIN;
  wire still_grab_active = state == CFDW_STILL;

  // sticky flags: set beats clear
  logic [7:0] events;
  always_comb
  begin
    events = 8'h00;
    events[ST_CAPDONE] = cap_done_ev;
    events[ST_FRMDONE] = frm_done_ev && video_on;
    events[ST_Q0OVF +: 3] = queue_overflow & {3{dma_on}};
    events[ST_HBOVF] = hblank_done && &queue_overflow;
    events[ST_VSYNC] = pix_vsync;
    next_status = irq_status;
    if (reg_wr && reg_addr == OFS_STATUS) next_status = next_status & ~reg_wdata[7:0];
    next_status = (next_status | events) & 8'hdf; // line counter flag unused
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

  // read port, unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_ENABLE: reg_rdata <= {29'h0, transfer_enable};
        OFS_CONFIG: reg_rdata <= transfer_config;
        OFS_HWIN: reg_rdata <= horizontal_window;
        OFS_VWIN: reg_rdata <= vertical_window;
        OFS_BASE0: reg_rdata <= plane0_base_addr;
        OFS_BASE1: reg_rdata <= plane1_base_addr;
        OFS_BASE2: reg_rdata <= plane2_base_addr;
        OFS_STRIDE: reg_rdata <= line_stride;
        OFS_MIRROR: reg_rdata <= mirror_size;
        OFS_CAPCTL: reg_rdata <= {30'h0, video_on, 1'b0};
        OFS_CAPSTA: reg_rdata <= {29'h0, current_field_flag, video_grab_active,
          still_grab_active};
        OFS_MASK: reg_rdata <= {24'h0, irq_mask};
        OFS_STATUS: reg_rdata <= {24'h0, irq_status};
        OFS_FTIMER: reg_rdata <= {8'h0, frame_clocks};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else reg_rdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// [verification/cfdw_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module cfdw_sva
  import cfdw_pkg::*;
#(
  parameter int TIMER_DIV = FT_TICK_DIV
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] input_format,
  input wire logic pix_vsync,
  input wire logic pix_valid,
  input wire logic [1:0] pix_plane,
  input wire logic mem_wr_valid,
  input wire logic [1:0] mem_wr_plane,
  input wire logic [31:0] mem_wr_data,
  input wire logic [11:0] min_burst_bytes,
  input wire logic irq
);
  logic dma_on;
  logic [31:0] cfg;
  logic [7:0] mask;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // shadow copies of checked fields
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dma_on <= 1'b0;
      cfg <= 32'h0000_0000;
      mask <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_ENABLE)
        dma_on <= reg_wdata[0];
      if (reg_addr == OFS_CONFIG)
        cfg <= reg_wdata;
      if (reg_addr == OFS_MASK)
        mask <= reg_wdata[7:0];
    end
  end
  // armed frame start
  sequence s_vs_armed;
    pix_vsync && dma_on && mask[ST_VSYNC];
  endsequence
  // config steady a cycle
  sequence s_cfg_settled;
    cfg == $past(cfg);
  endsequence
  chk_wr_enabled: assert property (
    mem_wr_valid |-> $past(pix_valid) && $past(dma_on))
    else $error("write without pixel");
  chk_wr_plane: assert property (
    mem_wr_valid |-> mem_wr_plane == $past(pix_plane))
    else $error("wrong queue");
  chk_burst_size: assert property (
    s_cfg_settled |-> min_burst_bytes == (cfg[12] ? 12'h100 : 12'h100 << cfg[1:0]))
    else $error("bad burst size");
  chk_pad_fill: assert property (
    mem_wr_valid && $past(input_format) == CFDW_IN_RAW && $past(cfg[18:16]) == 3'b110
    |-> mem_wr_data[31:24] == $past(cfg[31:24]))
    else $error("bad fill byte");
  chk_irq_quiet: assert property (
    mask == 8'h00 && $past(mask) == 8'h00 |-> !irq)
    else $error("irq while masked");
  chk_vsync_irq: assert property (
    s_vs_armed |-> ##[1:3] irq)
    else $error("no vsync irq");
  chk_sta_reserved: assert property (
    reg_rd && reg_addr == OFS_CAPSTA |=> reg_rdata[31:3] == 29'h0000_0000)
    else $error("reserved bits set");
  chk_irq_hold: assert property (
    irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("irq dropped");
endmodule
bind cfdw_top cfdw_sva #(.TIMER_DIV(TIMER_DIV)) u_sva (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_format(input_format),
  .pix_vsync(pix_vsync), .pix_valid(pix_valid), .pix_plane(pix_plane),
  .mem_wr_valid(mem_wr_valid), .mem_wr_plane(mem_wr_plane), .mem_wr_data(mem_wr_data),
  .min_burst_bytes(min_burst_bytes), .irq(irq));
`default_nettype wire

// [verification/cfdw_pix_src.sv]
`timescale 1ns/1ns
`default_nettype none
module cfdw_pix_src (
  input wire logic clk,
  output logic pix_vsync,
  output logic pix_valid,
  output logic pix_sol,
  output logic [1:0] pix_plane,
  output logic [31:0] pix_data,
  output logic pix_field,
  output logic field_end,
  output logic hblank_done,
  output logic [2:0] queue_overflow
);
  // idle parser
  initial
  begin
    pix_vsync = 1'b0;
    pix_valid = 1'b0;
    pix_sol = 1'b0;
    pix_plane = 2'b00;
    pix_data = 32'h0000_0000;
    pix_field = 1'b0;
    field_end = 1'b0;
    hblank_done = 1'b0;
    queue_overflow = 3'b000;
  end
  // one frame on queue 0, data holds line and pixel
  task automatic send_frame(input int nl, input int np, input logic fld);
    @(posedge clk);
    pix_vsync <= 1'b1;
    pix_field <= fld;
    @(posedge clk);
    pix_vsync <= 1'b0;
    for (int l = 0; l < nl; l++)
    begin
      for (int p = 0; p < np; p++)
      begin
        pix_valid <= 1'b1;
        pix_sol <= (p == 0);
        pix_data <= {8'h5a, 8'h00, 8'(l), 8'(p)};
        @(posedge clk);
      end
      // idle word is inverted so a stale pixel can never look fresh
      pix_valid <= 1'b0;
      pix_sol <= 1'b0;
      pix_data <= ~pix_data;
      hblank_done <= 1'b1;
      @(posedge clk);
      hblank_done <= 1'b0;
    end
    field_end <= 1'b1;
    @(posedge clk);
    field_end <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // queues full past blanking
  task automatic overflow_all();
    @(posedge clk);
    queue_overflow <= 3'b111;
    @(posedge clk);
    hblank_done <= 1'b1;
    @(posedge clk);
    hblank_done <= 1'b0;
    queue_overflow <= 3'b000;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb
  import cfdw_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, pix_data, mem_wr_addr, mem_wr_data, rv;
  logic [1:0] input_format = CFDW_IN_RAW;
  logic bt656_mode = 1'b0;
  logic pix_vsync, pix_valid, pix_sol, pix_field, field_end, hblank_done, mem_wr_valid, irq;
  logic [1:0] pix_plane, mem_wr_plane;
  logic [2:0] queue_overflow;
  logic [11:0] min_burst_bytes;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam logic [7:0] RA[9] = '{OFS_ENABLE, OFS_CONFIG, OFS_HWIN, OFS_VWIN, OFS_BASE0,
    OFS_BASE1, OFS_BASE2, OFS_STRIDE, OFS_MIRROR};
  localparam logic [31:0] RV[9] = '{32'h0000_0000, 32'h0000_0000, 32'h0500_0000,
    32'h02d0_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0280_0500, 32'h02d0_0500};
  localparam logic [31:0] RM[9] = '{32'h0000_0007, 32'hff0f_3cc3, 32'h1fff_1fff,
    32'h1fff_1fff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h3fff_3fff, 32'h1fff_1fff};
  localparam logic [1:0] LF[4] = '{CFDW_IN_RAW, CFDW_IN_YUV420, CFDW_IN_YUV420, CFDW_IN_YUV422};
  localparam logic [3:0] LC[4] = '{4'b0011, 4'b0000, 4'b0001, 4'b0000};
  localparam int LN[4] = '{0, 0, 2, 2};
  always #4 sys_clk = ~sys_clk;
  cfdw_top #(.TIMER_DIV(2)) uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_format(input_format), .bt656_mode(bt656_mode), .pix_vsync(pix_vsync),
    .pix_valid(pix_valid), .pix_sol(pix_sol), .pix_plane(pix_plane), .pix_data(pix_data),
    .pix_field(pix_field), .field_end(field_end), .hblank_done(hblank_done),
    .queue_overflow(queue_overflow), .mem_wr_valid(mem_wr_valid), .mem_wr_plane(mem_wr_plane),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .min_burst_bytes(min_burst_bytes),
    .irq(irq));
  cfdw_pix_src src (.clk(sys_clk), .pix_vsync(pix_vsync), .pix_valid(pix_valid),
    .pix_sol(pix_sol), .pix_plane(pix_plane), .pix_data(pix_data), .pix_field(pix_field),
    .field_end(field_end), .hblank_done(hblank_done), .queue_overflow(queue_overflow));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data stands one cycle after strobe
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    rv = reg_rdata;
    chk(n, e, rv & m);
  endtask
  // expected addresses, stride 0x40
  task automatic expect_wr(input logic [31:0] b, input int nl, input int np, input int bpp,
      input int mw, input int ml);
    chk("count", nl * np, wa.size());
    for (int y = 0; y < nl; y++)
      for (int x = 0; x < np; x++)
        if (wa.size() > 0)
          chk("addr", b + (ml > 0 ? ml - 1 - y : y) * 64
            + (mw > 0 ? mw - 1 - x : x) * bpp, wa.pop_front());
    wa.delete();
    wd.delete();
  endtask
  // log writes, cut a hang
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (mem_wr_valid === 1'b1)
    begin
      wa.push_back(mem_wr_addr);
      wd.push_back(mem_wr_data);
    end
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // reset values and read-back
    for (int i = 0; i < 9; i++)
    begin
      rchk("reset", RA[i], 32'hffff_ffff, RV[i]);
      wr(RA[i], 32'hffff_ffff);
      rchk("readback", RA[i], 32'hffff_ffff, RM[i]);
    end
    rchk("mask reset", OFS_MASK, 32'hffff_ffff, 32'h0000_0000);
    wr(OFS_CAPSTA, 32'hffff_ffff);
    rchk("ro state", OFS_CAPSTA, 32'hffff_ffff, 32'h0000_0000);
    rchk("unmapped", 8'h44, 32'hffff_ffff, 32'h0000_0000);
    for (int c = 0; c < 5; c++)
    begin
      wr(OFS_CONFIG, c == 4 ? 32'h0000_1003 : 32'(c));
      repeat (2) @(posedge sys_clk);
      chk("burst", c == 4 ? 32'h0000_0100 : 32'h0000_0100 << c, 32'(min_burst_bytes));
    end
    // 4x2 crop at (1,1), raw8 frame, video
    wr(OFS_ENABLE, 32'h0000_0001);
    wr(OFS_CONFIG, 32'h0008_0000);
    wr(OFS_HWIN, 32'h0004_0001);
    wr(OFS_VWIN, 32'h0002_0001);
    wr(OFS_STRIDE, 32'h0000_0040);
    wr(OFS_MIRROR, 32'h0002_0004);
    wr(OFS_BASE0, 32'h1000_0000);
    wr(OFS_MASK, 32'h0000_0080);
    wr(OFS_CAPCTL, 32'h0000_0002);
    // mid-frame base waits a frame
    fork
      src.send_frame(4, 7, 1'b0);
      begin
        repeat (6) @(posedge sys_clk);
        wr(OFS_BASE0, 32'h2000_0000);
      end
    join
    expect_wr(32'h1000_0000, 2, 4, 1, 0, 0);
    chk1("irq", 1'b1, irq);
    rchk("status", OFS_STATUS, 32'h0000_0083, 32'h0000_0082);
    rchk("vcap on", OFS_CAPSTA, 32'h0000_0002, 32'h0000_0002);
    rchk("timer off", OFS_FTIMER, 32'hffff_ffff, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_00ff);
    rchk("cleared", OFS_STATUS, 32'hffff_ffff, 32'h0000_0000);
    chk1("irq clear", 1'b0, irq);
    wr(OFS_CONFIG, 32'h0008_3000);
    src.send_frame(4, 7, 1'b0);
    expect_wr(32'h2000_0000, 2, 4, 1, 4, 2);
    wr(OFS_CONFIG, 32'h0008_0400);
    src.send_frame(4, 7, 1'b0);
    expect_wr(32'h2000_0000, 0, 4, 1, 0, 0);
    src.send_frame(4, 7, 1'b1);
    expect_wr(32'h2000_0000, 2, 4, 1, 0, 0);
    wr(OFS_CONFIG, 32'h0008_00c0);
    repeat (4) src.send_frame(4, 7, 1'b0);
    expect_wr(32'h2000_0000, 2, 4, 1, 0, 0);
    for (int k = 0; k < 4; k++)
    begin
      input_format <= LF[k];
      wr(OFS_CONFIG, {12'h000, LC[k], 16'h0000});
      src.send_frame(4, 7, 1'b0);
      expect_wr(32'h2000_0000, LN[k], 4, 1, 0, 0);
    end
    // padded rgb, one 2-pixel line
    input_format <= CFDW_IN_RAW;
    wr(OFS_CONFIG, 32'hc30e_0000);
    wr(OFS_HWIN, 32'h0002_0000);
    wr(OFS_VWIN, 32'h0001_0000);
    src.send_frame(1, 2, 1'b0);
    chk("fill", 32'hc300_0001, wd[1]);
    expect_wr(32'h2000_0000, 1, 2, 4, 0, 0);
    src.overflow_all();
    rchk("hb ovf", OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
    wr(OFS_STATUS, 32'h0000_00ff);
    // video off mid-frame ends that frame
    fork
      src.send_frame(1, 2, 1'b0);
      begin
        repeat (3) @(posedge sys_clk);
        wr(OFS_CAPCTL, 32'h0000_0000);
      end
    join
    expect_wr(32'h2000_0000, 1, 2, 4, 0, 0);
    rchk("vcap off", OFS_CAPSTA, 32'h0000_0003, 32'h0000_0000);
    rchk("video done", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_00ff);
    wr(OFS_CAPCTL, 32'h0000_0001);
    src.send_frame(1, 2, 1'b0);
    expect_wr(32'h2000_0000, 1, 2, 4, 0, 0);
    rchk("still done", OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    src.send_frame(1, 2, 1'b0);
    expect_wr(32'h2000_0000, 0, 2, 4, 0, 0);
    wr(OFS_CAPCTL, 32'h0000_0002);
    wr(OFS_ENABLE, 32'h0000_0000);
    src.send_frame(1, 2, 1'b0);
    expect_wr(32'h2000_0000, 0, 2, 4, 0, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
